// ===== core/hub_boot_consts.vh
// Constants for the hub boot-mode sequencer: stage codes, flash layout, timing.
// Included by the design files; definitions only.
`ifndef HUB_BOOT_CONSTS_VH
`define HUB_BOOT_CONSTS_VH

`define ST_STANDBY 4'h0
`define ST_HARDWARE_INIT_STAGE 4'h1
`define ST_FW_FLASH 4'h2
`define ST_FW_SENSE 4'h3
`define ST_SOC_CFG 4'h4
`define ST_MERGE 4'h5
`define ST_IDLE 4'h6
`define ST_SUSPEND 4'h7
`define ST_CHARGER_DETECT_STAGE 4'h8
`define ST_ATTACH 4'h9
`define ST_NORMAL 4'hA

`define SIG_ADDR 16'hFFFA
`define EXEC_ADDR 16'h0000
`define SIG_WORD 32'h32444655
`define CFG_END_ADDR 8'hFF
`define FLASH_RATE_LOW_MHZ 30
`define FLASH_RATE_HIGH_MHZ 60
`define CLK_MHZ 250
`define CLK_NS 4
`define LOCK_TIME_NS 1000
`define LOCK_CYCLES ((`LOCK_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define SENSE_TIME_NS 2000
`define SENSE_CYCLES ((`SENSE_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define DEF_WORD 8'h00

`endif

// ===== core/cfg_merge_store.v
// Small configuration store: defaults, SoC-written and OTP words, merged on read.
// Assumes one clock, synchronous active-high clear from the sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "hub_boot_consts.vh"

module cfg_merge_store #(
    parameter AW = 4,
    parameter DEPTH = 16
) (
    input wire clk,
    input wire clear,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [AW-1:0] rd_addr,
    input wire [7:0] otp_data,
    input wire otp_valid,
    output reg [7:0] rd_data
);
    reg [7:0] soc_mem [0:DEPTH-1];
    reg [DEPTH-1:0] soc_set_q;
    wire [7:0] soc_word;

    assign soc_word = soc_mem[rd_addr];

    always @(posedge clk) begin
        if (wr_en) begin
            soc_mem[wr_addr] <= wr_data;
        end
    end

    // Clearing only the valid bits lets the memory stay plain RAM
    always @(posedge clk) begin
        if (clear) begin
            soc_set_q <= {DEPTH{1'b0}};
        end else if (wr_en) begin
            soc_set_q[wr_addr] <= 1'b1;
        end
    end

    // Priority: SoC write over OTP over built-in default
    always @(posedge clk) begin
        if (clear) begin
            rd_data <= `DEF_WORD;
        end else if (soc_set_q[rd_addr]) begin
            rd_data <= soc_word;
        end else if (otp_valid) begin
            rd_data <= otp_data;
        end else begin
            rd_data <= `DEF_WORD;
        end
    end
endmodule
`default_nettype wire

// ===== core/hub_boot_mode_sequencer.v
// Operating-mode and boot-stage sequencer of a USB hub.
// Assumes flash reads, SMBus slave, OTP and charger detector sit outside and
// talk through plain request/done ports; pins are synchronised here.
// Summary of operation
// [R01] Reset input low: standby, regulators off, pads high impedance, only reset watched.
// [R02] Reset input high: run as configurable hub with charger detection.
// [R03] Standby keeps no configuration; everything re-initialised after reset rises.
// [R04] Hardware init enables core regulator, resets logic, locks PLL, latches straps.
// [R05] No SMBus response during hardware init.
// [R06] Leave hardware init only when a reference clock is present.
// [R07] Firmware init checks flash signature at 0xFFFA; valid runs external from 0x0000.
// [R08] Attached flash is 1 Mbit and supports 30 or 60 MHz.
// [R09] Flash port supports 1-bit and 2-bit transfers, modes 0 and 3.
// [R10] Without flash, weak pull-downs sense SMBus pull-ups.
// [R11] SMBus detected in firmware init moves to SoC configuration.
// [R12] SoC configuration waits with no timeout.
// [R13] SoC writes register 0xFF to end configuration.
// [R14] Merge defaults, SoC settings and OTP, then apply.
// [R15] After configuration go idle, then suspend without bus power or attach request.
// [R16] Bus power present: charger detect if enabled, else attach.
// [R17] Detection disabled skips to attach; enabled starts detection automatically.
// [R18] Detection done: attach, then normal mode.
// [R19] Reset low from any stage returns to standby.
// [R20] Soft disconnect holds the device in attach until negated.
// [R21] No SMBus during USB suspend.
// [R22] Keep-awake bit set keeps clock and SMBus through suspend.
// [R23] Speed strap low selects 30 MHz flash, high selects 60 MHz.
// [R24] Explicit stage state machine, forced to standby by reset.
`timescale 1ns/10ps
`default_nettype none
`include "hub_boot_consts.vh"

module hub_boot_mode_sequencer #(
    parameter CFG_AW = 4,
    parameter LOCK_CYCLES = `LOCK_CYCLES,
    parameter SENSE_CYCLES = `SENSE_CYCLES
) (
    input wire clk,
    input wire srst,
    input wire hw_reset_n,
    input wire ref_clock_in,
    input wire pll_locked,
    input wire flash_speed_strap,
    input wire flash_dual_strap,
    input wire flash_mode3_strap,
    input wire flash_done,
    input wire [31:0] flash_sig,
    output reg flash_rd_req,
    output reg [15:0] flash_addr,
    output reg flash_60mhz,
    output reg flash_dual,
    output reg flash_mode3,
    output reg ext_rom_en,
    output reg [15:0] exec_addr,
    input wire smb_clk_pin,
    input wire smb_dat_pin,
    output reg smb_pulldown_en,
    output wire smb_enable,
    input wire smb_wr,
    input wire [7:0] smb_addr,
    input wire [7:0] smb_data,
    input wire [7:0] otp_data,
    input wire otp_valid,
    output reg [CFG_AW-1:0] cfg_idx,
    output wire [7:0] cfg_word,
    output reg cfg_apply,
    output reg cfg_done,
    input wire vbus_pin,
    input wire attach_req,
    input wire soft_disconnect,
    input wire usb_suspend,
    input wire suspend_awake_bit,
    input wire chg_det_enable,
    input wire chg_det_done,
    output reg chg_det_start,
    output reg core_reg_en,
    output reg logic_reset,
    output reg pads_enable,
    output reg core_clk_en,
    output reg attach_en,
    output reg [3:0] stage
);
    localparam CW = 16;
    localparam [31:0] LOCK_M1 = LOCK_CYCLES - 1;
    localparam [31:0] SENSE_M1 = SENSE_CYCLES - 1;
    localparam [CW-1:0] LOCK_LAST = LOCK_M1[CW-1:0];
    localparam [CW-1:0] SENSE_LAST = SENSE_M1[CW-1:0];
    localparam [CFG_AW-1:0] CFG_LAST = {CFG_AW{1'b1}};

    reg [1:0] rst_s_q, ref_s_q, vbus_s_q, scl_s_q, sda_s_q;
    wire rst_ok, ref_ok, vbus_ok, bus_seen;
    reg [3:0] state_q, state_d;
    reg [CW-1:0] cnt_q;
    reg strap_taken_q;
    reg awake_q;
    wire cfg_wr;
    wire in_susp;

    // Pins from outside the clock domain pass two flops first
    always @(posedge clk) begin
        if (srst) begin
            rst_s_q <= 2'h0;
            ref_s_q <= 2'h0;
            vbus_s_q <= 2'h0;
            scl_s_q <= 2'h0;
            sda_s_q <= 2'h0;
        end else begin
            rst_s_q <= {rst_s_q[0], hw_reset_n};
            ref_s_q <= {ref_s_q[0], ref_clock_in};
            vbus_s_q <= {vbus_s_q[0], vbus_pin};
            scl_s_q <= {scl_s_q[0], smb_clk_pin};
            sda_s_q <= {sda_s_q[0], smb_dat_pin};
        end
    end
    assign rst_ok = rst_s_q[1];
    assign ref_ok = ref_s_q[1];
    assign vbus_ok = vbus_s_q[1];
    // [R10] Pull-ups win over pull-downs
    assign bus_seen = scl_s_q[1] & sda_s_q[1];

    function is_hub_stage;
        input [3:0] s;
        begin
            is_hub_stage = (s != `ST_STANDBY) && (s != `ST_HARDWARE_INIT_STAGE);
        end
    endfunction

    // [R05] SMBus gated in init
    // [R21] Off in suspend
    // [R22] Unless kept awake
    assign in_susp = (state_q == `ST_SUSPEND) || usb_suspend;
    assign smb_enable = is_hub_stage(state_q) && (!in_susp || awake_q);
    // [R13] Write to 0xFF ends config, not stored
    assign cfg_wr = smb_enable && smb_wr && (smb_addr != `CFG_END_ADDR) && (state_q == `ST_SOC_CFG);

    // [R24] Stage machine
    always @* begin
        state_d = state_q;
        case (state_q)
            `ST_STANDBY: begin
                // [R02] Reset high enters hub mode
                if (rst_ok) begin
                    state_d = `ST_HARDWARE_INIT_STAGE;
                end
            end
            `ST_HARDWARE_INIT_STAGE: begin
                // [R06] Needs reference clock
                // Clock may arrive long after the lock wait, so the count is a minimum
                if (cnt_q >= LOCK_LAST && pll_locked && ref_ok) begin
                    state_d = `ST_FW_FLASH;
                end
            end
            `ST_FW_FLASH: begin
                if (flash_done) begin
                    state_d = (flash_sig == `SIG_WORD) ? `ST_MERGE : `ST_FW_SENSE;
                end
            end
            `ST_FW_SENSE: begin
                // [R11] Bus found goes to SoC config
                if (cnt_q == SENSE_LAST) begin
                    state_d = bus_seen ? `ST_SOC_CFG : `ST_MERGE;
                end
            end
            `ST_SOC_CFG: begin
                // [R12] No timeout
                if (smb_enable && smb_wr && smb_addr == `CFG_END_ADDR) begin
                    state_d = `ST_MERGE;
                end
            end
            `ST_MERGE: begin
                if (cfg_idx == CFG_LAST && cnt_q[0]) begin
                    state_d = `ST_IDLE;
                end
            end
            `ST_IDLE, `ST_SUSPEND: begin
                // [R16] Bus power routes by charger enable
                if (vbus_ok) begin
                    state_d = chg_det_enable ? `ST_CHARGER_DETECT_STAGE : `ST_ATTACH;
                end else if (attach_req) begin
                    state_d = `ST_ATTACH;
                // [R15] Nothing present: suspend
                end else begin
                    state_d = `ST_SUSPEND;
                end
            end
            `ST_CHARGER_DETECT_STAGE: begin
                // [R17] Disabled mid-way skips to attach
                // [R18] Done goes to attach
                if (!chg_det_enable || chg_det_done) begin
                    state_d = `ST_ATTACH;
                end
            end
            `ST_ATTACH: begin
                // [R20] Held while soft disconnect
                if (!soft_disconnect) begin
                    state_d = `ST_NORMAL;
                end
            end
            `ST_NORMAL: begin
                if (soft_disconnect) begin
                    state_d = `ST_ATTACH;
                end
            end
            default: state_d = `ST_STANDBY;
        endcase
        // [R19] Reset low wins from any stage
        if (!rst_ok) begin
            state_d = `ST_STANDBY;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            state_q <= `ST_STANDBY;
            cnt_q <= {CW{1'b0}};
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                cnt_q <= {CW{1'b0}};
            end else if (cnt_q != {CW{1'b1}}) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // [R04] Hardware init actions, strap latch at first init cycle
    // [R03] Standby clears all settings
    // [R23] Speed strap picks flash rate
    always @(posedge clk) begin
        if (srst || state_q == `ST_STANDBY) begin
            strap_taken_q <= 1'b0;
            flash_60mhz <= 1'b0;
            flash_dual <= 1'b0;
            flash_mode3 <= 1'b0;
            awake_q <= 1'b0;
        end else begin
            if (state_q == `ST_HARDWARE_INIT_STAGE && !strap_taken_q) begin
                strap_taken_q <= 1'b1;
                flash_60mhz <= flash_speed_strap;
                // [R09] Width and mode from straps
                flash_dual <= flash_dual_strap;
                flash_mode3 <= flash_mode3_strap;
            end
            // [R22] Bit sampled before suspend only
            if (!in_susp) begin
                awake_q <= suspend_awake_bit;
            end
        end
    end

    // [R07] Signature read and boot source
    always @(posedge clk) begin
        if (srst || state_q == `ST_STANDBY) begin
            flash_rd_req <= 1'b0;
            flash_addr <= `EXEC_ADDR;
            ext_rom_en <= 1'b0;
            exec_addr <= `EXEC_ADDR;
        end else begin
            flash_rd_req <= (state_d == `ST_FW_FLASH) && !flash_done;
            flash_addr <= (state_d == `ST_FW_FLASH) ? `SIG_ADDR : `EXEC_ADDR;
            if (state_q == `ST_FW_FLASH && flash_done && flash_sig == `SIG_WORD) begin
                ext_rom_en <= 1'b1;
                exec_addr <= `EXEC_ADDR;
            end
        end
    end

    // [R14] Walk config words through merge and apply
    always @(posedge clk) begin
        if (srst || state_q != `ST_MERGE) begin
            cfg_idx <= {CFG_AW{1'b0}};
            cfg_apply <= 1'b0;
        end else begin
            // Apply on the second cycle, when the stored word matches cfg_idx
            cfg_apply <= !cnt_q[0];
            if (cnt_q[0] && cfg_idx != CFG_LAST) begin
                cfg_idx <= cfg_idx + {{(CFG_AW-1){1'b0}}, 1'b1};
            end
        end
    end

    cfg_merge_store #(
        .AW(CFG_AW),
        .DEPTH(1 << CFG_AW)
    ) u_store (
        .clk(clk),
        .clear(state_q == `ST_STANDBY),
        .wr_en(cfg_wr),
        .wr_addr(smb_addr[CFG_AW-1:0]),
        .wr_data(smb_data),
        .rd_addr(cfg_idx),
        .otp_data(otp_data),
        .otp_valid(otp_valid),
        .rd_data(cfg_word)
    );

    // [R01] Standby outputs all off except logic_reset, held high
    always @(posedge clk) begin
        if (srst) begin
            core_reg_en <= 1'b0;
            logic_reset <= 1'b1;
            pads_enable <= 1'b0;
            core_clk_en <= 1'b0;
            smb_pulldown_en <= 1'b0;
            chg_det_start <= 1'b0;
            attach_en <= 1'b0;
            cfg_done <= 1'b0;
            stage <= `ST_STANDBY;
        end else begin
            core_reg_en <= (state_d != `ST_STANDBY);
            logic_reset <= (state_d == `ST_STANDBY) || (state_q == `ST_STANDBY);
            pads_enable <= is_hub_stage(state_d);
            // Clock gated in suspend unless kept awake
            core_clk_en <= (state_d != `ST_STANDBY) && ((state_d != `ST_SUSPEND && !usb_suspend) || awake_q);
            smb_pulldown_en <= (state_d == `ST_FW_SENSE);
            // [R17] Detection starts automatically
            chg_det_start <= (state_d == `ST_CHARGER_DETECT_STAGE) && (state_q != `ST_CHARGER_DETECT_STAGE);
            attach_en <= (state_d == `ST_NORMAL);
            cfg_done <= (state_d == `ST_IDLE) || (cfg_done && state_d != `ST_STANDBY);
            stage <= state_d;
        end
    end
endmodule
`default_nettype wire

// ===== test/hub_boot_sva.sv
// Checker for the boot-mode sequencer, bound to the top module's ports.
// Assumes one clock domain with srst as its synchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "hub_boot_consts.vh"
module hub_boot_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic hw_reset_n,
    input wire logic ref_clock_in,
    input wire logic flash_done,
    input wire logic [31:0] flash_sig,
    input wire logic ext_rom_en,
    input wire logic smb_pulldown_en,
    input wire logic smb_enable,
    input wire logic smb_wr,
    input wire logic [7:0] smb_addr,
    input wire logic soft_disconnect,
    input wire logic usb_suspend,
    input wire logic suspend_awake_bit,
    input wire logic chg_det_enable,
    input wire logic chg_det_start,
    input wire logic core_reg_en,
    input wire logic core_clk_en,
    input wire logic [3:0] stage
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic awake_m;
    // keep-awake bit counts only as last seen before any suspend
    always @(posedge clk) begin
        if (srst || stage == `ST_STANDBY) begin
            awake_m <= 1'b0;
        end else if (stage != `ST_SUSPEND && !usb_suspend) begin
            awake_m <= suspend_awake_bit;
        end
    end
    sequence s_sig_seen;
        stage == `ST_FW_FLASH && flash_done;
    endsequence
    sequence s_cfg_end;
        stage == `ST_SOC_CFG && smb_wr && smb_addr == `CFG_END_ADDR;
    endsequence
    sequence s_chg_enter;
        stage == `ST_CHARGER_DETECT_STAGE && $past(stage) != `ST_CHARGER_DETECT_STAGE;
    endsequence
    // Four low samples cover the pin synchroniser latency
    a_reset_standby: assert property (!hw_reset_n [*4] |-> stage == `ST_STANDBY && !core_reg_en)
        else $error("reset low did not reach standby");
    a_hwinit_quiet: assert property (stage == `ST_HARDWARE_INIT_STAGE |-> core_reg_en && !smb_enable)
        else $error("hardware init not quiet");
    a_hwinit_ref: assert property ((stage == `ST_HARDWARE_INIT_STAGE && !ref_clock_in) [*3] |=> stage == `ST_HARDWARE_INIT_STAGE)
        else $error("left hardware init without reference clock");
    a_sig_good: assert property (s_sig_seen ##0 flash_sig == `SIG_WORD |=> stage == `ST_MERGE ##[0:1] ext_rom_en)
        else $error("valid signature not taken");
    a_sig_bad: assert property (s_sig_seen ##0 flash_sig != `SIG_WORD |=> stage == `ST_FW_SENSE)
        else $error("bad signature did not start sensing");
    a_sense_pd: assert property (stage == `ST_FW_SENSE |-> smb_pulldown_en)
        else $error("no pull-downs while sensing");
    a_cfg_end: assert property (s_cfg_end |=> stage == `ST_MERGE)
        else $error("end marker did not close configuration");
    a_cfg_wait: assert property (stage == `ST_SOC_CFG && hw_reset_n && !(smb_wr && smb_addr == `CFG_END_ADDR)
        |=> stage == `ST_SOC_CFG)
        else $error("configuration stage left early");
    a_chg_start: assert property (s_chg_enter |-> $past(chg_det_enable) ##[0:1] chg_det_start)
        else $error("charger detection entry wrong");
    a_soft_disc: assert property (stage == `ST_NORMAL && soft_disconnect |-> ##[1:3] stage == `ST_ATTACH)
        else $error("soft disconnect ignored");
    a_susp_quiet: assert property ((stage == `ST_SUSPEND || usb_suspend) && !awake_m
        |-> !smb_enable)
        else $error("bus served in suspend");
    a_susp_awake: assert property (stage == `ST_SUSPEND && awake_m
        |-> smb_enable && core_clk_en)
        else $error("keep-awake suspend lost bus");
endmodule
bind hub_boot_mode_sequencer hub_boot_sva u_sva (.clk, .srst, .hw_reset_n, .ref_clock_in, .flash_done,
    .flash_sig, .ext_rom_en, .smb_pulldown_en, .smb_enable, .smb_wr, .smb_addr, .soft_disconnect, .usb_suspend,
    .suspend_awake_bit, .chg_det_enable, .chg_det_start, .core_reg_en, .core_clk_en, .stage);
`default_nettype wire

// ===== test/soc_flash_model.sv
// SoC bus host and SPI flash stand-in for the sequencer's far side.
// Assumes the bench sets sig_ok and bus_present before each boot.
`timescale 1ns/10ps
`default_nettype none
`include "hub_boot_consts.vh"
module soc_flash_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic flash_rd_req,
    input wire logic sig_ok,
    input wire logic bus_present,
    input wire logic smb_pulldown_en,
    input wire logic [3:0] stage,
    input wire logic [7:0] soc_word,
    output var logic flash_done,
    output var logic [31:0] flash_sig,
    output wire logic smb_clk_pin,
    output wire logic smb_dat_pin,
    output var logic smb_wr,
    output var logic [7:0] smb_addr,
    output var logic [7:0] smb_data
);
    logic [5:0] cnt;
    logic tgl;
    assign smb_clk_pin = bus_present | (!smb_pulldown_en & tgl);
    assign smb_dat_pin = bus_present | (!smb_pulldown_en & !tgl);
    always @(posedge clk) begin
        tgl <= !tgl;
        flash_done <= 1'h0;
        smb_wr <= 1'h0;
        // Released lines keep changing so a stale value never looks valid
        flash_sig <= ~flash_sig;
        smb_addr <= ~smb_addr;
        smb_data <= ~smb_data;
        cnt <= (flash_rd_req || stage == `ST_SOC_CFG) ? cnt + 6'h01 : 6'h00;
        if (srst) begin
            {tgl, flash_sig, smb_addr, smb_data, cnt} <= 55'h0;
        // slow signature answer, same at either strapped rate
        end else if (flash_rd_req && cnt == 6'h05) begin
            flash_done <= 1'h1;
            flash_sig <= sig_ok ? `SIG_WORD : ~`SIG_WORD;
        end else if (stage == `ST_SOC_CFG && cnt == 6'h28) begin
            smb_wr <= 1'h1;
            smb_addr <= 8'h03;
            smb_data <= soc_word;
        end else if (stage == `ST_SOC_CFG && cnt == 6'h30) begin
            smb_wr <= 1'h1;
            smb_addr <= `CFG_END_ADDR;
        end
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench: four boot runs through flash, bus and default paths.
// Assumes the far-side model answers flash reads and bus writes.
`timescale 1ns/10ps
`default_nettype none
`include "hub_boot_consts.vh"
module testbench;
    logic clk, srst, hw_reset_n, ref_clock_in, flash_speed_strap, flash_dual_strap, flash_mode3_strap;
    logic otp_valid, vbus_pin, attach_req, soft_disconnect, usb_suspend, suspend_awake_bit, chg_det_enable;
    logic chg_det_done, flash_done, flash_rd_req, flash_60mhz, flash_dual, flash_mode3, ext_rom_en;
    logic smb_clk_pin, smb_dat_pin, smb_pulldown_en, smb_enable, smb_wr, cfg_apply, cfg_done, chg_det_start;
    logic core_reg_en, logic_reset, pads_enable, core_clk_en, attach_en, sig_ok, bus_present, soc_run;
    logic [7:0] otp_data, soc_word, smb_addr, smb_data, cfg_word;
    logic [31:0] flash_sig, rnd;
    logic [15:0] flash_addr, exec_addr;
    logic [3:0] cfg_idx, stage, last_st, exp_st;
    logic [3:0] q[$];
    integer mismatches, check_count;
    wire pll_locked = ref_clock_in;
    hub_boot_mode_sequencer #(.LOCK_CYCLES(4), .SENSE_CYCLES(4)) u_dut (.clk, .srst, .hw_reset_n,
        .ref_clock_in, .pll_locked, .flash_speed_strap, .flash_dual_strap, .flash_mode3_strap, .flash_done,
        .flash_sig, .flash_rd_req, .flash_addr, .flash_60mhz, .flash_dual, .flash_mode3, .ext_rom_en,
        .exec_addr, .smb_clk_pin, .smb_dat_pin, .smb_pulldown_en, .smb_enable, .smb_wr, .smb_addr,
        .smb_data, .otp_data, .otp_valid, .cfg_idx, .cfg_word, .cfg_apply, .cfg_done, .vbus_pin,
        .attach_req, .soft_disconnect, .usb_suspend, .suspend_awake_bit, .chg_det_enable, .chg_det_done,
        .chg_det_start, .core_reg_en, .logic_reset, .pads_enable, .core_clk_en, .attach_en, .stage);
    soc_flash_model u_soc (.clk, .srst, .flash_rd_req, .sig_ok, .bus_present, .smb_pulldown_en, .stage,
        .soc_word, .flash_done, .flash_sig, .smb_clk_pin, .smb_dat_pin, .smb_wr, .smb_addr, .smb_data);
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count = check_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_st(input logic [3:0] s);
        integer n;
        n = 0;
        while (stage !== s && n < 2000) begin
            @(posedge clk);
            n = n + 1;
        end
        check(stage, s, "stage wait");
    endtask
    task automatic run(input logic ok, input logic pins, input logic vb, input logic ce, input logic aw);
        rnd = lfsr(rnd);
        {flash_speed_strap, flash_dual_strap, flash_mode3_strap} <= rnd[2:0];
        {otp_data, soc_word} <= rnd[23:8];
        {sig_ok, bus_present, vbus_pin, chg_det_enable, suspend_awake_bit} <= {ok, pins, vb, ce, aw};
        soc_run <= pins & ~ok;
        q.push_back(`ST_HARDWARE_INIT_STAGE);
        q.push_back(`ST_FW_FLASH);
        if (!ok) q.push_back(`ST_FW_SENSE);
        if (!ok && pins) q.push_back(`ST_SOC_CFG);
        q.push_back(`ST_MERGE);
        q.push_back(`ST_IDLE);
        if (!vb) q.push_back(`ST_SUSPEND);
        if (vb && ce) q.push_back(`ST_CHARGER_DETECT_STAGE);
        repeat (vb ? 2 : 0) begin
            q.push_back(`ST_ATTACH);
            q.push_back(`ST_NORMAL);
        end
        q.push_back(`ST_STANDBY);
        @(posedge clk);
        hw_reset_n <= 1'h1;
        // Reference clock arrives late so the init stage must wait for it
        repeat (10) @(posedge clk);
        ref_clock_in <= 1'h1;
        wait_st(`ST_FW_FLASH);
        check(flash_addr, `SIG_ADDR, "flash_addr");
        check({flash_60mhz, flash_dual, flash_mode3}, rnd[2:0], "flash_mode");
        check({logic_reset, pads_enable, exec_addr}, {1'h0, 1'h1, `EXEC_ADDR}, "init_outs");
        wait_st(`ST_IDLE);
        check({cfg_done, ext_rom_en}, {1'h1, ok}, "boot_src");
        if (vb) begin
            wait_st(`ST_NORMAL);
            check(attach_en, 1'h1, "attach_en");
            usb_suspend <= 1'h1;
            repeat (2) @(posedge clk);
            check(smb_enable, aw, "usb_susp_bus");
            usb_suspend <= 1'h0;
            soft_disconnect <= 1'h1;
            repeat (12) @(posedge clk);
            check(stage, `ST_ATTACH, "held_attach");
            soft_disconnect <= 1'h0;
            wait_st(`ST_NORMAL);
        end else begin
            wait_st(`ST_SUSPEND);
            repeat (6) @(posedge clk);
            check({smb_enable, core_clk_en}, {aw, aw}, "susp_awake");
        end
        hw_reset_n <= 1'h0;
        ref_clock_in <= 1'h0;
        wait_st(`ST_STANDBY);
        check({core_reg_en, pads_enable, attach_en, logic_reset}, 4'h1, "standby_outs");
    endtask
    always @(posedge clk) begin
        chg_det_done <= (stage === `ST_CHARGER_DETECT_STAGE) && (chg_det_start === 1'h0);
        if (srst) begin
            last_st <= `ST_STANDBY;
        end else if (stage !== last_st) begin
            last_st <= stage;
            exp_st = (q.size() > 0) ? q.pop_front() : 4'hF;
            check(stage, exp_st, "stage_order");
        end
        if (!srst && cfg_apply === 1'h1) begin
            check(cfg_word, (cfg_idx === 4'h3 && soc_run) ? soc_word : otp_data, "cfg_word");
        end
    end
    initial begin
        {srst, hw_reset_n, ref_clock_in, flash_speed_strap, flash_dual_strap, flash_mode3_strap} = 6'h20;
        {otp_valid, vbus_pin, attach_req, soft_disconnect, usb_suspend, suspend_awake_bit} = 6'h20;
        {chg_det_enable, chg_det_done, otp_data, soc_word, sig_ok, bus_present, soc_run} = 21'h0;
        mismatches = 0;
        check_count = 0;
        rnd = 32'h00012608;
        repeat (20) @(posedge clk);
        srst <= 1'h0;
        run(1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
        run(1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
        run(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
        run(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches = mismatches + 1;
        test_done;
    end
endmodule
`default_nettype wire
